// [inc/asc_map.svh]
// register offsets, reset values, limits and timing counts of the set-point scaler
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// byte offsets on the register bus
`define ASC_OFF_RANGE        8'h00
`define ASC_OFF_TYPE         8'h04
`define ASC_OFF_FILTER       8'h08
`define ASC_OFF_DISPLAY      8'h0C
`define ASC_OFF_VIEW         8'h10
`define ASC_OFF_THERM        8'h14
`define ASC_OFF_FIRST_GFREQ  8'h18
`define ASC_OFF_SECOND_GFREQ 8'h1C
`define ASC_OFF_FIRST_BFREQ  8'h20
`define ASC_OFF_FIRST_BLEV   8'h24
`define ASC_OFF_FIRST_GLEV   8'h28
`define ASC_OFF_SECOND_BFREQ 8'h2C
`define ASC_OFF_SECOND_BLEV  8'h30
`define ASC_OFF_SECOND_GLEV  8'h34
`define ASC_OFF_STATUS       8'h38
`define ASC_OFF_LEVEL        8'h3C
`define ASC_OFF_FREQ         8'h40

// reset values (frequency in 0.01 Hz, level in 0.1 %)
`define ASC_RST_RANGE        4'h1
`define ASC_RST_TYPE         2'h0
`define ASC_RST_FILTER       4'h1
`define ASC_RST_DISPLAY      1'h0
`define ASC_RST_VIEW         16'h0000
`define ASC_RST_THERM        16'h270F
`define ASC_RST_GFREQ        16'h1388
`define ASC_RST_BFREQ        16'h0000
`define ASC_RST_FIRST_BLEV   12'h000
`define ASC_RST_SECOND_BLEV  12'h0C8
`define ASC_RST_GLEV         12'h3E8

// legal limits and codes
`define ASC_THERM_OFF        16'h270F
`define ASC_MAX_FREQ         16'h9C40
`define ASC_MAX_LEVEL        12'hBB8
`define ASC_MAX_FILTER       4'h8
`define ASC_SCALE_FULL       12'h3E8
`define ASC_SCALE_HALF       12'h7D0

// filter sample period and per-setting shift (setting 8 in the top nibble)
`define ASC_CLK_PERIOD_NS    10
`define ASC_FILT_TICK_US     500
`define ASC_FILT_SHIFTS      36'hBA8764321

`endif

// [inc/asc_pkg.sv]
// types shared by the analog set-point scaler modules
package asc_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } asc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } asc_avs_rsp_t;

  // one calibration set per analog input
  typedef struct packed {
    logic [15:0] bias_freq;
    logic [15:0] gain_freq;
    logic [11:0] bias_level;
    logic [11:0] gain_level;
  } asc_cal_t;

  typedef struct packed {
    logic [23:0] acc;
  } asc_filt_state_t;

  typedef struct packed {
    logic [16:0] freq;
  } asc_interp_state_t;

  typedef struct packed {
    logic [3:0]        range;
    logic [1:0]        in_type;
    logic [3:0]        filter;
    logic              display;
    logic [15:0]       view;
    logic [15:0]       therm;
    asc_cal_t [1:0]    cal;
    logic [19:0]       tick_cnt;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [16:0]       freq;
    logic              valid;
    logic              reverse;
    logic              second;
    logic              mismatch;
  } asc_state_t;

endpackage

// [verilog/asc_lag_filter.sv]
// first-order lag filter for one analog input channel
`include "asc_map.svh"

module asc_lag_filter #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // control
  input  wire logic             tick_i,
  input  wire logic [3:0]       setting_i,
  // data
  input  wire logic [WIDTH-1:0] sample_i,
  output logic      [WIDTH-1:0] level_o
);
  import asc_pkg::*;

  localparam logic [35:0] SHIFTS = `ASC_FILT_SHIFTS;

  asc_filt_state_t st;
  asc_filt_state_t next_st;
  logic [3:0]      shift;
  logic signed [24:0] diff;

  always_comb begin
    next_st = st;
    shift   = SHIFTS[{setting_i, 2'b00} +: 4];
    diff    = $signed({1'b0, sample_i, 12'h000}) - $signed({1'b0, st.acc});
    // time constant doubles per step of the shift, roughly 1 ms up to 1 s [R08]
    if (tick_i) begin
      next_st.acc = st.acc + 24'(diff >>> shift);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.acc[23:12];

endmodule // asc_lag_filter

// [verilog/asc_interp.sv]
// bias/gain interpolation of one filtered level into a signed frequency
`include "asc_map.svh"

module asc_interp (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // operands
  input  wire logic [11:0]        level_i,
  input  wire asc_pkg::asc_cal_t  cal_i,
  input  wire logic               reversible_i,
  // result, 0.01 Hz, two's complement
  output logic [16:0]             freq_o
);
  import asc_pkg::*;

  asc_interp_state_t  st;
  asc_interp_state_t  next_st;
  logic signed [17:0] fspan;
  logic signed [13:0] loff;
  logic signed [13:0] lspan;
  logic signed [31:0] prod;
  logic signed [31:0] res;

  always_comb begin
    next_st = st;
    fspan   = $signed({2'b00, cal_i.gain_freq}) - $signed({2'b00, cal_i.bias_freq});
    loff    = $signed({2'b00, level_i}) - $signed({2'b00, cal_i.bias_level});
    lspan   = $signed({2'b00, cal_i.gain_level}) - $signed({2'b00, cal_i.bias_level});
    prod    = 32'(fspan * loff);
    res     = 32'(cal_i.bias_freq);
    // a bias frequency above the gain frequency just gives a negative span [R13]
    if (level_i >= cal_i.gain_level) begin
      res = 32'(cal_i.gain_freq); // [R19]
    end else if (lspan <= 0) begin
      res = 32'(cal_i.bias_freq);
    end else if (!reversible_i && loff <= 0) begin
      res = 32'(cal_i.bias_freq); // [R19]
    end else begin
      // below the bias point reversible mode extrapolates to negative values [R06] [R21]
      // bias kept signed so a negative quotient is not taken as a huge unsigned one
      res = $signed(32'(cal_i.bias_freq)) + prod / 32'(lspan);
    end
    if (res > 32'sh0000_9C40) begin
      res = 32'sh0000_9C40;
    end else if (res < -32'sh0000_9C40) begin
      res = -32'sh0000_9C40;
    end
    next_st.freq = res[16:0];
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign freq_o = st.freq;

endmodule // asc_interp

// [verilog/asc_scaler.sv]
// analog set-point scaler: input select, filter, calibration and register slave
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`include "asc_map.svh"

// Summary of operation
// R01 - second input is a frequency source only while its select input is high
// R02 - thermistor level other than 9999 disables the first input as command
// R03 - first input full scale 5 V or 10 V maps to gain frequency
// R04 - operator picks range 0 or 10 before applying 10 V
// R05 - second input type 1 or 2 with switch at voltage means voltage input
// R06 - range 10 and 11 allow reverse rotation on either input
// R07 - reversible default: second input below 4 mA reverses, above runs forward
// R08 - first-order lag filter, setting 0 to 8, about 1 ms to 1 s
// R09 - gain frequency per input, 0 to 400 Hz, default 50 Hz
// R10 - bias frequency per input, 0 to 400 Hz, default 0 Hz
// R11 - first input bias/gain level 0 to 300 %, default 0 % and 100 %
// R12 - second input bias/gain level 0 to 300 %, default 20 % and 100 %
// R13 - bias frequency above gain frequency gives an inverse characteristic
// R14 - display unit 0 shows percent, 1 shows volt or milliamp
// R15 - range, filter and calibration writable only while extended view is 0
// R16 - display unit writable at any time regardless of write protection
// R17 - gain frequency sets top frequency directly; range leaves ramp slopes alone
// R18 - range codes: 0 is 10 V, 1 is 5 V, 10 and 11 the same reversible
// R19 - command clamps to bias frequency below bias level, gain frequency above; in range 10 and 11 the code extrapolates below bias instead
// R20 - operator assigns the select function by writing code 4 to a terminal
// R21 - linear interpolation between bias and gain, signed in reversible mode
module asc_scaler #(
  parameter int TICK_CYCLES = (`ASC_FILT_TICK_US * 1000) / `ASC_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  // register bus
  input  wire asc_pkg::asc_avs_req_t avs_req_i,
  output asc_pkg::asc_avs_rsp_t      avs_rsp_o,
  // analog levels, 12-bit converter codes, full code = 10 V or 20 mA
  input  wire logic [11:0]           first_level_i,
  input  wire logic [11:0]           second_level_i,
  input  wire logic                  second_input_select_i,
  input  wire logic                  current_switch_i,
  // frequency command
  output logic [16:0]                freq_cmd_o,
  output logic                       cmd_valid_o,
  output logic                       reverse_o,
  output logic                       second_active_o,
  output logic                       type_mismatch_o,
  output logic                       level_display_unit_o
);
  import asc_pkg::*;

  asc_state_t  st;
  asc_state_t  next_st;
  logic        tick;
  logic [11:0] raw [2];
  logic [11:0] filt [2];
  logic [11:0] pct [2];
  logic [11:0] scale [2];
  logic [1:0]  unit [2];
  logic [16:0] interp_freq;
  logic [11:0] act_level;
  asc_cal_t    act_cal;
  logic [31:0] rd_val;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic [11:0] wr_level;
  logic        locked;
  logic        reversible;

  // display unit codes: 0 = 0-5 V, 1 = 0-10 V, 2 = 0-20 mA
  function automatic logic [15:0] to_disp(input logic [11:0] p, input logic [1:0] u,
                                          input logic en);
    logic [15:0] v;
    v = {4'h0, p};
    if (en) begin
      unique case (u)
        2'h0:    v = {5'h00, p[11:1]};
        2'h2:    v = {3'h0, p, 1'b0};
        default: v = {4'h0, p};
      endcase
    end
    return v;
  endfunction

  function automatic logic [11:0] from_disp(input logic [15:0] v, input logic [1:0] u,
                                            input logic en);
    logic [16:0] p;
    p = {1'b0, v};
    if (en) begin
      unique case (u)
        2'h0:    p = {v, 1'b0};
        2'h2:    p = {2'b00, v[15:1]};
        default: p = {1'b0, v};
      endcase
    end
    return (p > 17'(`ASC_MAX_LEVEL)) ? 12'hFFF : p[11:0];
  endfunction

  assign raw[0] = first_level_i;
  assign raw[1] = second_level_i;

  // range code bit 0 set means the 5 V span on the first input [R03] [R18]
  assign unit[0] = st.range[0] ? 2'h0 : 2'h1;
  assign unit[1] = (st.in_type == 2'h1) ? 2'h0 : ((st.in_type == 2'h2) ? 2'h1 : 2'h2);
  assign reversible = st.range[3]; // [R06] [R18]
  assign tick = (st.tick_cnt == 20'(TICK_CYCLES - 1));

  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic [23:0] prod;
    asc_lag_filter #(
      .WIDTH     (12)
    ) u_filter (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .tick_i    (tick),
      .setting_i (st.filter),
      .sample_i  (raw[g]),
      .level_o   (filt[g])
    );
    // half-scale code is full scale on a 5 V span [R03]
    assign scale[g] = (unit[g] == 2'h0) ? `ASC_SCALE_HALF : `ASC_SCALE_FULL;
    assign prod     = filt[g] * scale[g];
    assign pct[g]   = prod[23:12];
  end

  // terminal select picks the second input, otherwise the first [R01]
  assign act_level = second_input_select_i ? pct[1] : pct[0];
  assign act_cal   = second_input_select_i ? st.cal[1] : st.cal[0];

  asc_interp u_interp (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .level_i      (act_level),
    .cal_i        (act_cal),
    .reversible_i (reversible),
    .freq_o       (interp_freq)
  );

  // read view of every register; levels appear in the chosen display unit
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (avs_req_i.address)
      `ASC_OFF_RANGE:        rd_val = {28'h0, st.range};
      `ASC_OFF_TYPE:         rd_val = {30'h0, st.in_type};
      `ASC_OFF_FILTER:       rd_val = {28'h0, st.filter};
      `ASC_OFF_DISPLAY:      rd_val = {31'h0, st.display};
      `ASC_OFF_VIEW:         rd_val = {16'h0, st.view};
      `ASC_OFF_THERM:        rd_val = {16'h0, st.therm};
      `ASC_OFF_FIRST_GFREQ:  rd_val = {16'h0, st.cal[0].gain_freq};
      `ASC_OFF_SECOND_GFREQ: rd_val = {16'h0, st.cal[1].gain_freq};
      `ASC_OFF_FIRST_BFREQ:  rd_val = {16'h0, st.cal[0].bias_freq};
      `ASC_OFF_SECOND_BFREQ: rd_val = {16'h0, st.cal[1].bias_freq};
      `ASC_OFF_FIRST_BLEV:   rd_val = {16'h0, to_disp(st.cal[0].bias_level, unit[0],
                                                      st.display)}; // [R14]
      `ASC_OFF_FIRST_GLEV:   rd_val = {16'h0, to_disp(st.cal[0].gain_level, unit[0],
                                                      st.display)};
      `ASC_OFF_SECOND_BLEV:  rd_val = {16'h0, to_disp(st.cal[1].bias_level, unit[1],
                                                      st.display)};
      `ASC_OFF_SECOND_GLEV:  rd_val = {16'h0, to_disp(st.cal[1].gain_level, unit[1],
                                                      st.display)};
      `ASC_OFF_STATUS:       rd_val = {28'h0, st.mismatch, st.reverse, st.second, st.valid};
      `ASC_OFF_LEVEL:        rd_val = {16'h0, to_disp(act_level,
                                                      second_input_select_i ? unit[1] : unit[0],
                                                      st.display)};
      `ASC_OFF_FREQ:         rd_val = {{15{st.freq[16]}}, st.freq};
      default:               rd_val = 32'h0000_0000;
    endcase
  end

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign be_mask[b*8 +: 8] = {8{avs_req_i.byteenable[b]}};
  end

  // byte lanes not enabled keep the value seen on read
  assign wr_val = (rd_val & ~be_mask) | (avs_req_i.writedata & be_mask);

  always_comb begin
    next_st  = st;
    locked   = (st.view != 16'h0000);
    wr_level = 12'h000;
    // filter sample tick divider
    next_st.tick_cnt = tick ? 20'h00000 : st.tick_cnt + 20'h00001;

    // one wait cycle, then the answer; a write lands on the edge waitrequest is low
    next_st.waitreq = 1'b1;
    if ((avs_req_i.read || avs_req_i.write) && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = avs_req_i.read ? rd_val : 32'h0000_0000;
    end
    if (!st.waitreq && avs_req_i.write) begin
      unique case (avs_req_i.address)
        `ASC_OFF_RANGE: begin
          // codes 0, 1, 10 and 11 only [R18]
          if (!locked && (wr_val[3:0] == 4'h0 || wr_val[3:0] == 4'h1 ||
                          wr_val[3:0] == 4'hA || wr_val[3:0] == 4'hB)) begin
            next_st.range = wr_val[3:0]; // [R15]
          end
        end
        `ASC_OFF_TYPE: begin
          if (!locked && wr_val[1:0] != 2'h3) begin
            next_st.in_type = wr_val[1:0]; // [R15]
          end
        end
        `ASC_OFF_FILTER: begin
          if (!locked && wr_val[3:0] <= `ASC_MAX_FILTER) begin
            next_st.filter = wr_val[3:0]; // [R08] [R15]
          end
        end
        `ASC_OFF_DISPLAY: begin
          next_st.display = wr_val[0]; // [R16]
        end
        `ASC_OFF_VIEW: begin
          next_st.view = wr_val[15:0];
        end
        `ASC_OFF_THERM: begin
          next_st.therm = wr_val[15:0];
        end
        `ASC_OFF_FIRST_GFREQ, `ASC_OFF_SECOND_GFREQ: begin
          // takes effect on the command at once, no input level needed [R09] [R17]
          if (!locked && wr_val[15:0] <= `ASC_MAX_FREQ) begin
            next_st.cal[avs_req_i.address[2]].gain_freq = wr_val[15:0];
          end
        end
        `ASC_OFF_FIRST_BFREQ: begin
          if (!locked && wr_val[15:0] <= `ASC_MAX_FREQ) begin
            next_st.cal[0].bias_freq = wr_val[15:0]; // [R10]
          end
        end
        `ASC_OFF_SECOND_BFREQ: begin
          if (!locked && wr_val[15:0] <= `ASC_MAX_FREQ) begin
            next_st.cal[1].bias_freq = wr_val[15:0]; // [R10]
          end
        end
        `ASC_OFF_FIRST_BLEV, `ASC_OFF_FIRST_GLEV: begin
          wr_level = from_disp(wr_val[15:0], unit[0], st.display); // [R14]
          if (!locked && wr_level <= `ASC_MAX_LEVEL) begin
            if (avs_req_i.address == `ASC_OFF_FIRST_BLEV) begin
              next_st.cal[0].bias_level = wr_level; // [R11]
            end else begin
              next_st.cal[0].gain_level = wr_level; // [R11]
            end
          end
        end
        `ASC_OFF_SECOND_BLEV, `ASC_OFF_SECOND_GLEV: begin
          wr_level = from_disp(wr_val[15:0], unit[1], st.display); // [R14]
          if (!locked && wr_level <= `ASC_MAX_LEVEL) begin
            if (avs_req_i.address == `ASC_OFF_SECOND_BLEV) begin
              next_st.cal[1].bias_level = wr_level; // [R12]
            end else begin
              next_st.cal[1].gain_level = wr_level; // [R12]
            end
          end
        end
        default: begin
          next_st.view = st.view;
        end
      endcase
    end

    // a type/switch disagreement blocks the second input rather than guess [R05]
    next_st.mismatch = ((st.in_type == 2'h0) != current_switch_i);
    next_st.second   = second_input_select_i;
    if (second_input_select_i) begin
      next_st.valid = !next_st.mismatch; // [R01]
    end else begin
      next_st.valid = (st.therm == `ASC_THERM_OFF); // [R02]
    end
    // default second-input bias of 20 % puts reverse below 4 mA [R07]
    next_st.freq    = next_st.valid ? interp_freq : 17'h00000;
    next_st.reverse = next_st.valid && interp_freq[16];
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st                   <= '0;
      st.range             <= `ASC_RST_RANGE;
      st.in_type           <= `ASC_RST_TYPE;
      st.filter            <= `ASC_RST_FILTER;
      st.display           <= `ASC_RST_DISPLAY;
      st.view              <= `ASC_RST_VIEW;
      st.therm             <= `ASC_RST_THERM;
      st.cal[0].gain_freq  <= `ASC_RST_GFREQ;
      st.cal[0].bias_freq  <= `ASC_RST_BFREQ;
      st.cal[0].bias_level <= `ASC_RST_FIRST_BLEV;
      st.cal[0].gain_level <= `ASC_RST_GLEV;
      st.cal[1].gain_freq  <= `ASC_RST_GFREQ;
      st.cal[1].bias_freq  <= `ASC_RST_BFREQ;
      st.cal[1].bias_level <= `ASC_RST_SECOND_BLEV;
      st.cal[1].gain_level <= `ASC_RST_GLEV;
      st.waitreq           <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign avs_rsp_o.readdata    = st.rdata;
  assign avs_rsp_o.waitrequest = st.waitreq;
  assign freq_cmd_o            = st.freq;
  assign cmd_valid_o           = st.valid;
  assign reverse_o             = st.reverse;
  assign second_active_o       = st.second;
  assign type_mismatch_o       = st.mismatch;
  assign level_display_unit_o  = st.display;

endmodule // asc_scaler

// [sim/asc_scaler_asserts.sv]
// concurrent checks on the ports of the set-point scaler
module asc_scaler_asserts #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  // register bus
  input  wire asc_pkg::asc_avs_req_t avs_req_i,
  input  wire asc_pkg::asc_avs_rsp_t avs_rsp_o,
  // command side
  input  wire logic                  second_input_select_i,
  input  wire logic [16:0]           freq_cmd_o,
  input  wire logic                  cmd_valid_o,
  input  wire logic                  reverse_o,
  input  wire logic                  second_active_o,
  input  wire logic                  type_mismatch_o,
  input  wire logic                  level_display_unit_o
);
  import asc_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire logic req = avs_req_i.read | avs_req_i.write;

  a_wait_answer: assert property (req && avs_rsp_o.waitrequest |=> !avs_rsp_o.waitrequest)
    else $error("bus request not answered after one cycle");
  a_wait_pulse: assert property (!avs_rsp_o.waitrequest |=> avs_rsp_o.waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!req |=> avs_rsp_o.waitrequest)
    else $error("answer without request");
  a_rd_unmapped: assert property (avs_req_i.read && !avs_rsp_o.waitrequest &&
    avs_req_i.address > 8'h40 |-> avs_rsp_o.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_freq_zero: assert property (!cmd_valid_o |-> freq_cmd_o == 17'h0)
    else $error("command nonzero while not valid");
  a_reverse_sign: assert property (reverse_o == freq_cmd_o[16])
    else $error("reverse flag disagrees with sign");
  a_select_follow: assert property (!$past(reset_i) |->
    second_active_o == $past(second_input_select_i))
    else $error("second input flag not following select");
  a_mismatch_block: assert property (second_active_o && type_mismatch_o |-> !cmd_valid_o)
    else $error("command valid despite type mismatch");
  a_display_write: assert property (avs_req_i.write && !avs_rsp_o.waitrequest &&
    avs_req_i.address == 8'h0C && avs_req_i.byteenable[0]
    |=> level_display_unit_o == $past(avs_req_i.writedata[0]))
    else $error("display unit write not taken");

  c_reverse: cover property (reverse_o && cmd_valid_o);
  c_second: cover property (second_active_o && cmd_valid_o);
  c_mismatch: cover property (type_mismatch_o);
endmodule // asc_scaler_asserts

bind asc_scaler asc_scaler_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o),
  .second_input_select_i(second_input_select_i), .freq_cmd_o(freq_cmd_o),
  .cmd_valid_o(cmd_valid_o), .reverse_o(reverse_o), .second_active_o(second_active_o),
  .type_mismatch_o(type_mismatch_o), .level_display_unit_o(level_display_unit_o));

// [sim/asc_source_model.sv]
// analog set-point source: slews each level toward its target code
module asc_source_model (
  // clock
  input  wire logic        mclk_i,
  // targets from the bench
  input  wire logic [11:0] first_tgt_i,
  input  wire logic [11:0] second_tgt_i,
  input  wire logic        slow_i,
  input  wire logic        select_req_i,
  // levels seen by the scaler
  output logic      [11:0] first_level_o,
  output logic      [11:0] second_level_o,
  output logic             second_input_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a slow adjuster moves 0x080 codes a cycle, so the filter sees a ramp
  function automatic logic [11:0] slew(input logic [11:0] c, input logic [11:0] t,
                                       input logic s);
    if (!s || (c > t ? c - t : t - c) <= 12'h080) return t;
    return c > t ? c - 12'h080 : c + 12'h080;
  endfunction
  initial begin
    first_level_o = 12'h000;
    second_level_o = 12'h000;
    second_input_select_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    first_level_o <= slew(first_level_o, first_tgt_i, slow_i);
    second_level_o <= slew(second_level_o, second_tgt_i, slow_i);
    second_input_select_o <= select_req_i;
  end
endmodule // asc_source_model

// [sim/asc_scaler_test.sv]
// self-checking bench of the set-point scaler
module asc_scaler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  localparam int TICKS = 4;
  localparam logic [7:0] DA [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                                     8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
  localparam logic [15:0] DV [14] = '{16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h270F, 16'h1388,
                                      16'h1388, 16'h0, 16'h0, 16'h3E8, 16'h0, 16'hC8, 16'h3E8};
  localparam logic [3:0] RC [4] = '{4'h0, 4'h1, 4'hA, 4'hB};
  logic          mclk_i;
  logic          reset_i;
  asc_avs_req_t  avs_req;
  asc_avs_rsp_t  avs_rsp;
  logic [11:0]   first_lvl, second_lvl, first_tgt, second_tgt;
  logic          slow, sel_req, sel, switch_cur;
  logic [16:0]   freq;
  logic          valid, rev, sec, mism, disp;
  int            error_cnt, checked;

  asc_source_model src_u (.mclk_i(mclk_i), .first_tgt_i(first_tgt), .second_tgt_i(second_tgt),
    .slow_i(slow), .select_req_i(sel_req), .first_level_o(first_lvl),
    .second_level_o(second_lvl), .second_input_select_o(sel));
  asc_scaler #(.TICK_CYCLES(TICKS)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
    .avs_req_i(avs_req), .avs_rsp_o(avs_rsp), .first_level_i(first_lvl),
    .second_level_i(second_lvl), .second_input_select_i(sel), .current_switch_i(switch_cur),
    .freq_cmd_o(freq), .cmd_valid_o(valid), .reverse_o(rev), .second_active_o(sec),
    .type_mismatch_o(mism), .level_display_unit_o(disp));

  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  // request held until waitrequest is sampled low at a rising edge, released there
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 20);
    r = avs_rsp.readdata;
    if (n >= 20) miss("bus answer missing");
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    checked++;
    if (x !== e) miss($sformatf("reg %h read %h, expected %h", a, x, e));
  endtask

  task automatic cmp_out(input logic [16:0] g, input logic [16:0] e, input string what);
    checked++;
    if (g !== e) miss($sformatf("%s is %h, expected %h", what, g, e));
  endtask

  // wait for the filtered command to land, bounded
  task automatic settle(input logic [16:0] f, input logic v);
    int n;
    n = 0;
    @(negedge mclk_i);
    while ((freq !== f || valid !== v) && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    cmp_out(freq, f, "command");
    cmp_out({16'h0, valid}, {16'h0, v}, "valid");
    // hand back at a rising edge so the next stimulus lands there
    @(posedge mclk_i);
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    miss("watchdog expired");
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    reset_i = 1'b1;
    avs_req = '0;
    switch_cur = 1'b1;
    first_tgt = 12'h000;
    second_tgt = 12'h000;
    slow = 1'b0;
    sel_req = 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (DA[i]) cmp_reg(DA[i], {16'h0, DV[i]});
    cmp_reg(8'h44, 32'h0);
    wr(8'h0C, 32'h1);
    @(negedge mclk_i);
    cmp_out({16'h0, disp}, 17'h1, "display unit");
    cmp_reg(8'h28, 32'h1F4);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h0);
    cmp_reg(8'h00, 32'h1);
    wr(8'h0C, 32'h1);
    cmp_reg(8'h0C, 32'h1);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h9C41);
    cmp_reg(8'h18, 32'h1388);
    wr(8'h08, 32'h9);
    cmp_reg(8'h08, 32'h1);
    foreach (RC[i]) begin
      wr(8'h00, {28'h0, RC[i]});
      cmp_reg(8'h00, {28'h0, RC[i]});
    end
    wr(8'h00, 32'h2);
    cmp_reg(8'h00, 32'hB);
    wr(8'h00, 32'h0);
    wr(8'h28, 32'h1F4);
    first_tgt <= 12'hFFF;
    settle(17'h1388, 1'b1);
    cmp_reg(8'h40, 32'h1388);
    wr(8'h18, 32'hFA0);
    settle(17'h0FA0, 1'b1);
    wr(8'h20, 32'h3E8);
    first_tgt <= 12'h000;
    settle(17'h03E8, 1'b1);
    slow <= 1'b1;
    wr(8'h20, 32'h1770);
    wr(8'h18, 32'h7D0);
    settle(17'h1770, 1'b1);
    first_tgt <= 12'hFFF;
    settle(17'h07D0, 1'b1);
    wr(8'h14, 32'h64);
    settle(17'h0, 1'b0);
    wr(8'h14, 32'h270F);
    settle(17'h07D0, 1'b1);
    sel_req <= 1'b1;
    settle(17'h0, 1'b1);
    cmp_out({16'h0, sec}, 17'h1, "second active");
    switch_cur <= 1'b0;
    settle(17'h0, 1'b0);
    cmp_out({16'h0, mism}, 17'h1, "mismatch");
    wr(8'h04, 32'h1);
    settle(17'h0, 1'b1);
    wr(8'h04, 32'h0);
    switch_cur <= 1'b1;
    wr(8'h00, 32'hA);
    settle(17'h1FB1E, 1'b1);
    cmp_out({16'h0, rev}, 17'h1, "reverse");
    cmp_reg(8'h40, 32'hFFFFFB1E);
    cmp_reg(8'h38, 32'h7);
    end_of_test();
  end
endmodule // asc_scaler_test
